/* File: inc/pdtc_consts.vh */
// constants for the power domain transition controller
// =====================================================================
// Behaviour
// - writing one to clear bit drops request
// - writing zero to command bits does nothing
// - dsp go evaluates domain and its modules
// - always-on go evaluates its modules only
// - only mismatching domain or modules are moved
// - dsp busy bit reads one while moving
// - always-on busy bit reads one while moving
// - request flag set when the dsp domain needs power applied or removed
// - state encoding: zero off, one on
`ifndef PDTC_CONSTS_VH
`define PDTC_CONSTS_VH

// =====================================================================
// register byte offsets
`define OFF_EXT_PENDING     12'h000
`define OFF_EXT_CLEAR       12'h004
`define OFF_TRANS_CMD       12'h008
`define OFF_TRANS_STATUS    12'h00C
`define OFF_DOMAIN_CTRL     12'h010
`define OFF_DOMAIN_STATE    12'h014
`define OFF_MODULE_CTRL     12'h018
`define OFF_MODULE_STATE    12'h01C
`define OFF_IRQ_STATUS      12'h020
`define OFF_IRQ_MASK        12'h024

// =====================================================================
// field positions
`define BIT_DSP             1
`define BIT_AON             0
`define BIT_DOM_NEXT        0
`define BIT_POWER_GOOD      8
`define BIT_EV_AON_DONE     0
`define BIT_EV_DSP_DONE     1
`define BIT_EV_EXT_REQ      2
`define MOD_COUNT           4
`define MOD_AON_LSB         0
`define MOD_DSP_LSB         4

// =====================================================================
// encodings and reset values
`define STATE_OFF           1'b0
`define STATE_ON            1'b1
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10
`define RST_MODULE_CTRL     8'h00
`define RST_IRQ_MASK        3'h0

// =====================================================================
// timing: module settle time, rounded up to whole cycles at 10 MHz
`define CLK_MHZ             10
`define SETTLE_NS           1000
`define SETTLE_CYC          ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)

`endif

/* File: rtl/domain_sequencer.v */
// sequencer that moves one power domain and its modules
`timescale 1ns/1ns
`include "pdtc_consts.vh"

module domain_sequencer #(
	parameter HAS_DOMAIN = 1
) (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       go,
	input  wire       dom_next,
	input  wire       power_good,
	input  wire [3:0] mod_next,
	output reg        busy,
	output reg        dom_state,
	output reg  [3:0] mod_state,
	output reg        ext_req,
	output reg        done
);

// =====================================================================
// states
localparam ST_IDLE = 2'b00;
localparam ST_MODS = 2'b01;
localparam ST_WAIT = 2'b10;
localparam ST_LAST = 2'b11;

// the header count is an integer; keep only the counter's eight bits
localparam integer SETTLE_INT = `SETTLE_CYC;
localparam [7:0]   SETTLE     = SETTLE_INT[7:0];

reg [1:0] state;      // sequencer state
reg       dom_tgt;    // latched domain target
reg [3:0] mod_tgt;    // latched module targets
reg [7:0] settle;     // module settle counter
reg       mods_done;  // modules already handled this pass

// =====================================================================
// powering up moves the domain first, powering down moves it last; the
// module targets are applied whatever the domain target is
always @(posedge aclk)
begin
	ext_req <= 1'b0;
	done    <= 1'b0;
	if (!aresetn)
	begin
		state     <= ST_IDLE;
		busy      <= 1'b0;
		dom_state <= `STATE_OFF;
		mod_state <= 4'h0;
		dom_tgt   <= `STATE_OFF;
		mod_tgt   <= 4'h0;
		settle    <= 8'h00;
		mods_done <= 1'b0;
	end
	else
	begin
		case (state)
		ST_IDLE:
		begin
			// a go pulse only ever arrives as a written one
			if (go)
			begin
				busy      <= 1'b1;
				dom_tgt   <= dom_next;
				mod_tgt   <= mod_next;
				mods_done <= 1'b0;
				settle    <= SETTLE;
				if (HAS_DOMAIN && dom_next != dom_state
					&& dom_next == `STATE_ON)
				begin
					ext_req <= 1'b1;
					state   <= ST_WAIT;
				end
				else
					state <= ST_MODS;
			end
		end
		ST_MODS:
		begin
			// only mismatching modules move, after the settle time
			if (mod_tgt == mod_state)
				state <= ST_LAST;
			else if (settle > 8'h01)
				settle <= settle - 8'h01;
			else
			begin
				mod_state <= mod_tgt;
				state     <= ST_LAST;
			end
		end
		ST_WAIT:
		begin
			// the domain changes once software reports the power
			if (power_good == dom_tgt)
			begin
				dom_state <= dom_tgt;
				settle    <= SETTLE;
				state     <= mods_done ? ST_IDLE : ST_MODS;
				if (mods_done)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
		ST_LAST:
		begin
			mods_done <= 1'b1;
			if (HAS_DOMAIN && dom_tgt != dom_state)
			begin
				ext_req <= 1'b1;
				state   <= ST_WAIT;
			end
			else
			begin
				busy  <= 1'b0;
				done  <= 1'b1;
				state <= ST_IDLE;
			end
		end
		default:
			state <= ST_IDLE;
		endcase
	end
end

endmodule

/* File: rtl/power_domain_transition_ctrl.v */
// axi4-lite register block and command logic for domain transitions
`timescale 1ns/1ns
`include "pdtc_consts.vh"

module power_domain_transition_ctrl (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         irq
);

// =====================================================================
// helpers

// merge write data into a register under the byte strobes
function [31:0] merge;
	input [31:0] old;
	input [31:0] data;
	input [3:0]  strb;
	integer      i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1)
			if (strb[i])
				merge[i*8 +: 8] = data[i*8 +: 8];
	end
endfunction

// true when an address names a register of this block
function mapped;
	input [11:0] addr;
	begin
		case (addr)
		`OFF_EXT_PENDING, `OFF_EXT_CLEAR, `OFF_TRANS_CMD,
		`OFF_TRANS_STATUS, `OFF_DOMAIN_CTRL, `OFF_DOMAIN_STATE,
		`OFF_MODULE_CTRL, `OFF_MODULE_STATE, `OFF_IRQ_STATUS,
		`OFF_IRQ_MASK:
			mapped = 1'b1;
		default:
			mapped = 1'b0;
		endcase
	end
endfunction

// =====================================================================
// write channel holding registers
reg [11:0] aw_addr;   // accepted write address
reg        aw_full;   // write address held
reg [31:0] w_data;    // accepted write data
reg [3:0]  w_strb;    // accepted byte strobes
reg        w_full;    // write data held

// =====================================================================
// software visible state
reg        dom_next;     // dsp domain requested state
reg        power_good;   // external power reported good
reg [7:0]  mod_next;     // requested module states, both domains
reg        ext_pending;  // external power request pending
reg [2:0]  irq_status;   // sticky event bits
reg [2:0]  irq_mask;     // event enables

// =====================================================================
// sequencer connections
wire       dsp_busy;     // dsp domain moving
wire       dsp_dom;      // dsp domain current state
wire [3:0] dsp_mods;     // dsp module current states
wire       dsp_req;      // dsp wants external power action
wire       dsp_done;     // dsp pass finished
wire       aon_busy;     // always-on modules moving
wire [3:0] aon_mods;     // always-on module current states
wire       aon_done;     // always-on pass finished

// =====================================================================
// decoded write, combinational
reg        do_write;     // both halves held and response free
reg        wr_hit;       // write address is mapped
reg [7:0]  wr_byte0;     // low data byte, gated by its strobe
reg        go_dsp;       // dsp go pulse
reg        go_aon;       // always-on go pulse
reg        clr_ext;      // external request clear pulse
reg [31:0] mod_merged;   // module control after the byte merge
reg        next_aw_full;
reg        next_w_full;
reg        next_bvalid;
reg        next_rvalid;
reg [2:0]  next_irq_status;

// =====================================================================
// write decode; command and clear bits act only on a written one, so a
// zero or a masked lane changes nothing
always @*
begin
	do_write = aw_full && w_full && !s_axi_bvalid;
	wr_hit   = mapped(aw_addr);
	wr_byte0 = w_strb[0] ? w_data[7:0] : 8'h00;
	go_dsp   = do_write && aw_addr == `OFF_TRANS_CMD
		&& wr_byte0[`BIT_DSP];
	go_aon   = do_write && aw_addr == `OFF_TRANS_CMD
		&& wr_byte0[`BIT_AON];
	clr_ext  = do_write && aw_addr == `OFF_EXT_CLEAR
		&& wr_byte0[`BIT_DSP];
	mod_merged = merge({24'h00_0000, mod_next}, w_data, w_strb);
end

// =====================================================================
// handshake bookkeeping; each channel is taken on its own
always @*
begin
	next_aw_full = aw_full;
	next_w_full  = w_full;
	next_bvalid  = s_axi_bvalid;
	next_rvalid  = s_axi_rvalid;
	if (s_axi_awvalid && s_axi_awready)
		next_aw_full = 1'b1;
	if (s_axi_wvalid && s_axi_wready)
		next_w_full = 1'b1;
	if (do_write)
	begin
		next_aw_full = 1'b0;
		next_w_full  = 1'b0;
		next_bvalid  = 1'b1;
	end
	if (s_axi_bvalid && s_axi_bready)
		next_bvalid = 1'b0;
	if (s_axi_arvalid && s_axi_arready)
		next_rvalid = 1'b1;
	else if (s_axi_rvalid && s_axi_rready)
		next_rvalid = 1'b0;
end

// =====================================================================
// sticky events; a new event wins over a clear in the same cycle
always @*
begin
	next_irq_status = irq_status;
	if (do_write && aw_addr == `OFF_IRQ_STATUS)
		next_irq_status = irq_status & ~wr_byte0[2:0];
	if (aon_done)
		next_irq_status[`BIT_EV_AON_DONE] = 1'b1;
	if (dsp_done)
		next_irq_status[`BIT_EV_DSP_DONE] = 1'b1;
	if (dsp_req)
		next_irq_status[`BIT_EV_EXT_REQ] = 1'b1;
end

// =====================================================================
// write channel and register updates
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		aw_addr       <= 12'h000;
		aw_full       <= 1'b0;
		w_data        <= 32'h0000_0000;
		w_strb        <= 4'h0;
		w_full        <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready  <= 1'b0;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= `RESP_OKAY;
		dom_next      <= `STATE_OFF;
		power_good    <= 1'b0;
		mod_next      <= `RST_MODULE_CTRL;
		irq_mask      <= `RST_IRQ_MASK;
	end
	else
	begin
		aw_full       <= next_aw_full;
		w_full        <= next_w_full;
		s_axi_bvalid  <= next_bvalid;
		// each ready stays low while its own half is held or a response waits
		s_axi_awready <= !next_aw_full && !next_bvalid;
		s_axi_wready  <= !next_w_full && !next_bvalid;
		if (s_axi_awvalid && s_axi_awready)
			aw_addr <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (do_write)
		begin
			// unmapped addresses answer with an error, no side effect
			s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			case (aw_addr)
			`OFF_DOMAIN_CTRL:
			begin
				if (w_strb[0])
					dom_next <= w_data[`BIT_DOM_NEXT];
				if (w_strb[1])
					power_good <= w_data[`BIT_POWER_GOOD];
			end
			`OFF_MODULE_CTRL:
				mod_next <= mod_merged[7:0];
			`OFF_IRQ_MASK:
				irq_mask <= wr_byte0[2:0];
			default:
				irq_mask <= irq_mask;
			endcase
		end
	end
end

// =====================================================================
// pending request flag and interrupt; set wins over clear
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		ext_pending <= 1'b0;
		irq_status  <= 3'h0;
		irq         <= 1'b0;
	end
	else
	begin
		if (dsp_req)
			ext_pending <= 1'b1;
		else if (clr_ext)
			ext_pending <= 1'b0;
		irq_status <= next_irq_status;
		irq        <= |(next_irq_status & irq_mask);
	end
end

// =====================================================================
// read channel; write-only registers read as zero
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid  <= 1'b0;
		s_axi_rdata   <= 32'h0000_0000;
		s_axi_rresp   <= `RESP_OKAY;
	end
	else
	begin
		s_axi_rvalid  <= next_rvalid;
		s_axi_arready <= !next_rvalid;
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY
				: `RESP_SLVERR;
			case (s_axi_araddr)
			`OFF_EXT_PENDING:
				s_axi_rdata <= {30'h0000_0000, ext_pending, 1'b0};
			`OFF_TRANS_STATUS:
				s_axi_rdata <= {30'h0000_0000, dsp_busy,
					aon_busy};
			`OFF_DOMAIN_CTRL:
				s_axi_rdata <= {23'h00_0000, power_good, 7'h00,
					dom_next};
			`OFF_DOMAIN_STATE:
				s_axi_rdata <= {31'h0000_0000, dsp_dom};
			`OFF_MODULE_CTRL:
				s_axi_rdata <= {24'h00_0000, mod_next};
			`OFF_MODULE_STATE:
				s_axi_rdata <= {24'h00_0000, dsp_mods, aon_mods};
			`OFF_IRQ_STATUS:
				s_axi_rdata <= {29'h0000_0000, irq_status};
			`OFF_IRQ_MASK:
				s_axi_rdata <= {29'h0000_0000, irq_mask};
			default:
				s_axi_rdata <= 32'h0000_0000;
			endcase
		end
	end
end

// =====================================================================
// sequencers; a go while busy is dropped, software must wait
domain_sequencer #(
	.HAS_DOMAIN (1)
) u_dsp (
	.aclk       (aclk),
	.aresetn    (aresetn),
	.go         (go_dsp),
	.dom_next   (dom_next),
	.power_good (power_good),
	.mod_next   (mod_next[`MOD_DSP_LSB +: `MOD_COUNT]),
	.busy       (dsp_busy),
	.dom_state  (dsp_dom),
	.mod_state  (dsp_mods),
	.ext_req    (dsp_req),
	.done       (dsp_done)
);

// the always-on side has no domain level state of its own
domain_sequencer #(
	.HAS_DOMAIN (0)
) u_aon (
	.aclk       (aclk),
	.aresetn    (aresetn),
	.go         (go_aon),
	.dom_next   (1'b1),
	.power_good (1'b1),
	.mod_next   (mod_next[`MOD_AON_LSB +: `MOD_COUNT]),
	.busy       (aon_busy),
	.dom_state  (),
	.mod_state  (aon_mods),
	.ext_req    (),
	.done       (aon_done)
);

endmodule

/* File: testbench/pdtc_checker_sva.sv */
// assertion checker for the power domain transition controller
`timescale 1ns/1ns
`include "pdtc_consts.vh"

module pdtc_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire [11:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        irq
);
	// =================================================================
	// helper logic
	reg [11:0] rd_addr; // address of the read now being answered

	// latch the address at its handshake so the answer can be judged
	always @(posedge aclk)
	begin
		if (!aresetn)
			rd_addr <= 12'h000;
		else if (s_axi_arvalid && s_axi_arready)
			rd_addr <= s_axi_araddr;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// =================================================================
	// sequences and properties
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_reset_quiet: assert property ($rose(aresetn) |->
		!s_axi_bvalid && !s_axi_rvalid && !s_axi_arready && !irq)
		else $error("outputs not idle after reset");
	a_write_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered in time");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answer pending");
	a_write_blocks: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_status_rsvd: assert property (
		s_axi_rvalid && rd_addr == `OFF_TRANS_STATUS |->
		s_axi_rdata[31:2] == 30'h0)
		else $error("status register has stray bits");
	a_cmd_reads_zero: assert property (
		s_axi_rvalid && (rd_addr == `OFF_TRANS_CMD ||
		rd_addr == `OFF_EXT_CLEAR) |-> s_axi_rdata == 32'h0000_0000)
		else $error("write-only register reads nonzero");
	a_pending_rsvd: assert property (
		s_axi_rvalid && rd_addr == `OFF_EXT_PENDING |->
		s_axi_rdata[31:2] == 30'h0 && !s_axi_rdata[0])
		else $error("pending register has stray bits");
	a_state_code: assert property (
		s_axi_rvalid && rd_addr == `OFF_DOMAIN_STATE |->
		s_axi_rdata[31:1] == 31'h0)
		else $error("domain state outside off and on");
	a_unmapped_err: assert property (
		s_axi_rvalid && rd_addr > `OFF_IRQ_MASK |->
		s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
endmodule

bind power_domain_transition_ctrl pdtc_checker u_pdtc_checker (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .irq(irq));

/* File: testbench/power_domain_transition_ctrl_bench.sv */
// self-checking bench for the power domain transition controller
`timescale 1ns/1ns
`include "pdtc_consts.vh"

module power_domain_transition_ctrl_bench;
	// =================================================================
	// stimulus and observed signals
	reg        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	reg [11:0] awaddr, araddr;
	reg [31:0] wdata;
	reg [3:0]  wstrb;
	wire       awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int        fails, tests_run;

	power_domain_transition_ctrl u_power_domain_transition_ctrl (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq));

	// 100 ns period clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// =================================================================
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one write; each valid drops once its own channel is taken
	task automatic wr(input [11:0] a, input [31:0] d,
		input [1:0] er = `RESP_OKAY);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			n++;
		end
		while (!bvalid && n < 50);
		bready <= 1'b0;
		if (!bvalid)
		begin
			fails++;
			close_out();
		end
		check("bresp", {30'h0, bresp}, {30'h0, er});
	endtask

	// one read; the answer is taken at the edge rvalid is seen
	task automatic rd(input [11:0] a, output [31:0] d, output [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			n++;
		end
		while (!rvalid && n < 50);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		if (!rvalid)
		begin
			fails++;
			close_out();
		end
	endtask

	task automatic rchk(input string what, input [11:0] a,
		input [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check(what, d, exp);
	endtask

	// bounded poll; a field that never settles ends the run
	task automatic poll(input [11:0] a, input [31:0] m, input [31:0] w);
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		n = 0;
		do
		begin
			rd(a, d, r);
			n++;
		end
		while ((d & m) !== w && n < 300);
		check("poll", d & m, w);
		if ((d & m) !== w)
			close_out();
	endtask

	// =================================================================
	// scenarios
	task automatic t_reset_values;
		rchk("status", `OFF_TRANS_STATUS, 32'h0000_0000);
		rchk("dom", `OFF_DOMAIN_STATE, 32'h0000_0000);
		rchk("pending", `OFF_EXT_PENDING, 32'h0000_0000);
		check("irq", {31'h0, irq}, 32'h0000_0000);
	endtask

	// zero writes to command and clear must not start anything
	task automatic t_zero_cmd;
		wr(`OFF_MODULE_CTRL, 32'h0000_0005);
		wr(`OFF_TRANS_CMD, 32'h0000_0000);
		wr(`OFF_EXT_CLEAR, 32'h0000_0000);
		repeat (20) @(posedge aclk);
		rchk("mods", `OFF_MODULE_STATE, 32'h0000_0000);
		rchk("status", `OFF_TRANS_STATUS, 32'h0000_0000);
	endtask

	task automatic t_aon;
		wr(`OFF_TRANS_CMD, 32'h0000_0001);
		rchk("status", `OFF_TRANS_STATUS, 32'h0000_0001);
		poll(`OFF_TRANS_STATUS, 32'h0000_0001, 32'h0000_0000);
		rchk("mods", `OFF_MODULE_STATE, 32'h0000_0005);
		// second go with nothing to change leaves states alone
		wr(`OFF_TRANS_CMD, 32'h0000_0001);
		poll(`OFF_TRANS_STATUS, 32'h0000_0001, 32'h0000_0000);
		rchk("mods", `OFF_MODULE_STATE, 32'h0000_0005);
		check("irq", {31'h0, irq}, 32'h0000_0000);
		wr(`OFF_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		check("irq", {31'h0, irq}, 32'h0000_0001);
		wr(`OFF_IRQ_STATUS, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		check("irq", {31'h0, irq}, 32'h0000_0000);
	endtask

	// power-on waits for power good; clear drops the request flag
	task automatic t_dsp;
		wr(`OFF_MODULE_CTRL, 32'h0000_00A5);
		wr(`OFF_DOMAIN_CTRL, 32'h0000_0001);
		wr(`OFF_TRANS_CMD, 32'h0000_0002);
		rchk("status", `OFF_TRANS_STATUS, 32'h0000_0002);
		poll(`OFF_EXT_PENDING, 32'h0000_0002, 32'h0000_0002);
		rchk("dom", `OFF_DOMAIN_STATE, 32'h0000_0000);
		wr(`OFF_EXT_CLEAR, 32'h0000_0001);
		rchk("pending", `OFF_EXT_PENDING, 32'h0000_0002);
		wr(`OFF_EXT_CLEAR, 32'h0000_0002);
		rchk("pending", `OFF_EXT_PENDING, 32'h0000_0000);
		wr(`OFF_DOMAIN_CTRL, 32'h0000_0101);
		poll(`OFF_TRANS_STATUS, 32'h0000_0002, 32'h0000_0000);
		rchk("dom", `OFF_DOMAIN_STATE, 32'h0000_0001);
		rchk("mods", `OFF_MODULE_STATE, 32'h0000_00A5);
	endtask

	// power-off moves the modules first, then waits for power to drop
	task automatic t_dsp_off;
		wr(`OFF_MODULE_CTRL, 32'h0000_0005);
		wr(`OFF_DOMAIN_CTRL, 32'h0000_0100);
		wr(`OFF_TRANS_CMD, 32'h0000_0002);
		poll(`OFF_EXT_PENDING, 32'h0000_0002, 32'h0000_0002);
		rchk("mods", `OFF_MODULE_STATE, 32'h0000_0005);
		rchk("dom", `OFF_DOMAIN_STATE, 32'h0000_0001);
		rchk("status", `OFF_TRANS_STATUS, 32'h0000_0002);
		wr(`OFF_DOMAIN_CTRL, 32'h0000_0000);
		poll(`OFF_TRANS_STATUS, 32'h0000_0002, 32'h0000_0000);
		rchk("dom", `OFF_DOMAIN_STATE, 32'h0000_0000);
		rchk("events", `OFF_IRQ_STATUS, 32'h0000_0006);
		wr(`OFF_IRQ_MASK, 32'h0000_0004);
		repeat (2) @(posedge aclk);
		check("irq", {31'h0, irq}, 32'h0000_0001);
		wr(`OFF_IRQ_STATUS, 32'h0000_0006);
		rchk("events", `OFF_IRQ_STATUS, 32'h0000_0000);
		check("irq", {31'h0, irq}, 32'h0000_0000);
		rchk("pending", `OFF_EXT_PENDING, 32'h0000_0002);
		wr(`OFF_EXT_CLEAR, 32'h0000_0002);
		rchk("pending", `OFF_EXT_PENDING, 32'h0000_0000);
	endtask

	task automatic t_unmapped;
		logic [31:0] d;
		logic [1:0]  r;
		wr(12'h030, 32'hFFFF_FFFF, `RESP_SLVERR);
		rd(12'h030, d, r);
		check("rdata", d, 32'h0000_0000);
		check("rresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
		rchk("cmd", `OFF_TRANS_CMD, 32'h0000_0000);
	endtask

	// =================================================================
	// main sequence
	initial
	begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		fails = 0;
		tests_run = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset_values();
		t_zero_cmd();
		t_aon();
		t_dsp();
		t_dsp_off();
		t_unmapped();
		close_out();
	end
endmodule
